/* rtl/oesc_pin_sync.sv */
// two-flop synchroniser with rising edge pulse for a sync pin
`timescale 1ns/1ps
module oesc_pin_sync (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic pin_i,
    output logic rise_o
);
    logic meta;
    logic stable;
    logic prev;
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            // idle level of a pulled-up pin, so leaving reset shows no false edge
            meta <= 1'b1;
            stable <= 1'b1;
            prev <= 1'b1;
            rise_o <= 1'b0;
        end
        else
        begin
            meta <= pin_i;
            stable <= meta;
            prev <= stable;
            rise_o <= stable & ~prev;
        end
    end
endmodule

/* rtl/oesc_pkg.sv */
// constants shared by the exposure sequencer and sync pin control
// Behaviour
// - every emitter exposure gets an ambient cancel phase before conversion.
// - one, two or three emitters fire sequentially or together.
// - optional dark ambient exposure is taken in every sample.
// - single emitter without ambient pushes one result per sample.
// - single or simultaneous with ambient pushes optical then ambient result.
// - simultaneous mode lights all enabled emitters in one window, one result.
// - sequential mode pushes one result per emitter in order, then ambient.
// - three sequential emitters then one ambient exposure each sample.
// - four-bit mode field in sync_control at 0x10 sets both pin roles.
// - mode 0000 with A/B/C used: pin a low on external exposures, else high.
// - mode 0000 without A/B/C: pin a floats; pin b always disabled.
// - mode 0000 times samples and exposures from the internal oscillator.
// - mode 0001 takes a 32 kHz clock on pin b; pin a as in 0000.
// - modes 0010 and 0011 start one sample per trigger on pin a.
// - mode 0010 pin b is mux control, floating when A/B/C unused.
// - mode 0010 times exposures internally, sample start from trigger.
// - mode 0011 times exposures from the pin b clock.
// - fifo entry is a five-bit tag above a 19-bit value.
package oesc_pkg;
    localparam logic [7:0] SYNC_CTRL_ADDR = 8'h10;
    localparam logic [7:0] SEQ_CFG_ADDR = 8'h11;
    localparam logic [7:0] SLOT_CFG_ADDR = 8'h12;
    localparam logic [7:0] STATUS_ADDR = 8'h13;
    localparam logic [7:0] SYNC_CTRL_RST = 8'h00;
    localparam logic [7:0] SEQ_CFG_RST = 8'h00;
    localparam logic [7:0] SLOT_CFG_RST = 8'h00;
    localparam int SEQ_SIMUL_BIT = 0;
    localparam int SEQ_EMIT_LSB = 1;
    localparam int SEQ_AMB_BIT = 4;
    localparam int SEQ_RUN_BIT = 5;
    localparam int STATUS_OVR_BIT = 6;
    localparam logic [3:0] MODE_STANDALONE = 4'h0;
    localparam logic [3:0] MODE_EXT_CLK = 4'h1;
    localparam logic [3:0] MODE_TRIG = 4'h2;
    localparam logic [3:0] MODE_TRIG_EXT_CLK = 4'h3;
    localparam int VALUE_W = 19;
    localparam int TAG_W = 5;
    localparam int FIFO_W = 24;
    localparam logic [4:0] TAG_SIMUL = 5'h07;
    localparam logic [4:0] TAG_AMBIENT = 5'h0C;
    localparam logic [2:0] SLOT_EXT_FIRST = 3'h3;
    localparam logic [2:0] SLOT_AMB = 3'h6;
    localparam int CLK_HZ = 100000000;
    localparam int OSC_HZ = 32768;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int SAMPLE_TICKS = 32;
    localparam int COMP_TICKS = 1;
    localparam int EXPOSE_TICKS = 1;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_COMP = 4'b0010,
        ST_EXPOSE = 4'b0100,
        ST_CONV = 4'b1000
    } oesc_state_t;
endpackage

/* rtl/oesc_tick_div.sv */
// divider giving a one-cycle tick at the internal oscillator rate
`timescale 1ns/1ps
module oesc_tick_div #(
    parameter int DIV = oesc_pkg::OSC_DIV
) (
    input wire logic clk_i,
    input wire logic reset_i,
    output logic tick_o
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic next_tick;
    always_comb
    begin
        next_tick = (count == 16'(DIV - 1));
        next_count = next_tick ? 16'h0000 : count + 16'h0001;
    end
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            count <= 16'h0000;
            tick_o <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick_o <= next_tick;
        end
    end
endmodule

/* rtl/oesc_top.sv */
// exposure sequencer, result tagging and sync pin control
`timescale 1ns/1ps
module oesc_top #(
    parameter int SAMPLE_TICKS = oesc_pkg::SAMPLE_TICKS,
    parameter int COMP_TICKS = oesc_pkg::COMP_TICKS,
    parameter int EXPOSE_TICKS = oesc_pkg::EXPOSE_TICKS,
    parameter int OSC_DIV = oesc_pkg::OSC_DIV
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic sync_pin_a_i,
    output logic sync_pin_a_o,
    output logic sync_pin_a_oe_n_o,
    input wire logic sync_pin_b_i,
    output logic sync_pin_b_o,
    output logic sync_pin_b_oe_n_o,
    output logic [2:0] emitter_drive_o,
    output logic amb_cancel_o,
    output logic conv_start_o,
    input wire logic conv_done_i,
    input wire logic [18:0] conv_data_i,
    output logic fifo_push_o,
    output logic [23:0] fifo_data_o
);
    logic [7:0] sync_control, seq_cfg, slot_cfg;
    logic [7:0] next_sync_control, next_seq_cfg, next_slot_cfg, next_rdata;
    logic overrun, next_overrun;
    oesc_pkg::oesc_state_t state, next_state;
    logic [2:0] slot, next_slot, next_emit, emit_en;
    logic [7:0] phase_cnt, next_phase_cnt, period_cnt, next_period_cnt;
    logic next_cancel, next_conv_start, next_push;
    logic [23:0] next_fifo_data;
    logic next_a_o, next_a_oe_n, next_b_o, next_b_oe_n;
    logic int_tick, a_rise, b_rise, tick, start_req;
    logic [3:0] mode, first_hit, after_hit;
    logic ext_clk_mode, trig_mode, abc_en, simul, amb_en, ext_exposing;
    logic [6:0] mask;

    oesc_tick_div #(.DIV(OSC_DIV)) u_div (.clk_i(clk_i), .reset_i(reset_i), .tick_o(int_tick));
    oesc_pin_sync u_sync_a (.clk_i(clk_i), .reset_i(reset_i), .pin_i(sync_pin_a_i),
        .rise_o(a_rise));
    oesc_pin_sync u_sync_b (.clk_i(clk_i), .reset_i(reset_i), .pin_i(sync_pin_b_i),
        .rise_o(b_rise));

    // lowest enabled slot at or above 'from'; bit 3 flags a hit
    function automatic logic [3:0] find_slot(input logic [6:0] m, input logic [2:0] from);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 6; i >= 0; i--)
        begin
            if (m[i] && (3'(i) >= from))
            begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction

    always_comb
    begin
        mode = sync_control[3:0];
        ext_clk_mode = (mode == oesc_pkg::MODE_EXT_CLK) || (mode == oesc_pkg::MODE_TRIG_EXT_CLK);
        trig_mode = (mode == oesc_pkg::MODE_TRIG) || (mode == oesc_pkg::MODE_TRIG_EXT_CLK);
        abc_en = |slot_cfg[2:0];
        simul = seq_cfg[oesc_pkg::SEQ_SIMUL_BIT];
        emit_en = seq_cfg[oesc_pkg::SEQ_EMIT_LSB +: 3];
        amb_en = seq_cfg[oesc_pkg::SEQ_AMB_BIT];
        tick = ext_clk_mode ? b_rise : int_tick;
        // external emitters only exist as separate slots in sequential order
        mask = simul ? {amb_en, 5'h00, |emit_en} : {amb_en, slot_cfg[2:0], emit_en};
        first_hit = find_slot(mask, 3'h0);
        after_hit = (slot == oesc_pkg::SLOT_AMB) ? 4'h0 : find_slot(mask, slot + 3'h1);
        start_req = trig_mode ? a_rise : (tick && period_cnt == 8'(SAMPLE_TICKS - 1));
    end

    // register file and sample period counter
    always_comb
    begin
        next_sync_control = sync_control;
        next_seq_cfg = seq_cfg;
        next_slot_cfg = slot_cfg;
        next_overrun = overrun;
        next_rdata = 8'h00;
        next_period_cnt = period_cnt;
        if (wr_i && addr_i == oesc_pkg::SYNC_CTRL_ADDR)
        begin
            next_sync_control = wdata_i;
        end
        else if (wr_i && addr_i == oesc_pkg::SEQ_CFG_ADDR)
        begin
            next_seq_cfg = wdata_i;
        end
        else if (wr_i && addr_i == oesc_pkg::SLOT_CFG_ADDR)
        begin
            next_slot_cfg = {5'h00, wdata_i[2:0]};
        end
        else if (wr_i && addr_i == oesc_pkg::STATUS_ADDR && wdata_i[oesc_pkg::STATUS_OVR_BIT])
        begin
            next_overrun = 1'b0;
        end
        // a start that finds the sequencer busy is dropped; set beats clear
        if (start_req && state != oesc_pkg::ST_IDLE)
        begin
            next_overrun = 1'b1;
        end
        if (rd_i && addr_i == oesc_pkg::SYNC_CTRL_ADDR)
        begin
            next_rdata = sync_control;
        end
        else if (rd_i && addr_i == oesc_pkg::SEQ_CFG_ADDR)
        begin
            next_rdata = seq_cfg;
        end
        else if (rd_i && addr_i == oesc_pkg::SLOT_CFG_ADDR)
        begin
            next_rdata = slot_cfg;
        end
        else if (rd_i && addr_i == oesc_pkg::STATUS_ADDR)
        begin
            next_rdata = {1'b0, overrun, state != oesc_pkg::ST_IDLE, 2'b00, slot};
        end
        if (trig_mode)
        begin
            next_period_cnt = 8'h00;
        end
        else if (tick)
        begin
            next_period_cnt = (period_cnt == 8'(SAMPLE_TICKS - 1)) ? 8'h00 : period_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            sync_control <= oesc_pkg::SYNC_CTRL_RST;
            seq_cfg <= oesc_pkg::SEQ_CFG_RST;
            slot_cfg <= oesc_pkg::SLOT_CFG_RST;
            overrun <= 1'b0;
            rdata_o <= 8'h00;
            period_cnt <= 8'h00;
        end
        else
        begin
            sync_control <= next_sync_control;
            seq_cfg <= next_seq_cfg;
            slot_cfg <= next_slot_cfg;
            overrun <= next_overrun;
            rdata_o <= next_rdata;
            period_cnt <= next_period_cnt;
        end
    end

    // sequencer and its registered outputs
    always_comb
    begin
        next_state = state;
        next_slot = slot;
        next_phase_cnt = phase_cnt;
        next_conv_start = 1'b0;
        next_push = 1'b0;
        next_fifo_data = fifo_data_o;
        case (state)
            oesc_pkg::ST_IDLE:
            begin
                if (start_req && seq_cfg[oesc_pkg::SEQ_RUN_BIT] && first_hit[3])
                begin
                    next_slot = first_hit[2:0];
                    next_phase_cnt = 8'h00;
                    next_state = (first_hit[2:0] == oesc_pkg::SLOT_AMB)
                        ? oesc_pkg::ST_EXPOSE : oesc_pkg::ST_COMP;
                end
            end
            oesc_pkg::ST_COMP:
            begin
                if (tick)
                begin
                    next_phase_cnt = phase_cnt + 8'h01;
                    if (phase_cnt == 8'(COMP_TICKS - 1))
                    begin
                        next_phase_cnt = 8'h00;
                        next_state = oesc_pkg::ST_EXPOSE;
                    end
                end
            end
            oesc_pkg::ST_EXPOSE:
            begin
                if (tick)
                begin
                    next_phase_cnt = phase_cnt + 8'h01;
                    if (phase_cnt == 8'(EXPOSE_TICKS - 1))
                    begin
                        next_phase_cnt = 8'h00;
                        next_conv_start = 1'b1;
                        next_state = oesc_pkg::ST_CONV;
                    end
                end
            end
            oesc_pkg::ST_CONV:
            begin
                if (conv_done_i)
                begin
                    next_push = 1'b1;
                    next_fifo_data[18:0] = conv_data_i;
                    next_fifo_data[23:19] = (slot == oesc_pkg::SLOT_AMB) ? oesc_pkg::TAG_AMBIENT
                        : simul ? oesc_pkg::TAG_SIMUL
                        : {2'b00, slot} + 5'h01;
                    if (after_hit[3])
                    begin
                        next_slot = after_hit[2:0];
                        next_state = (after_hit[2:0] == oesc_pkg::SLOT_AMB)
                            ? oesc_pkg::ST_EXPOSE : oesc_pkg::ST_COMP;
                    end
                    else
                    begin
                        next_state = oesc_pkg::ST_IDLE;
                    end
                end
            end
            default:
            begin
                next_state = oesc_pkg::ST_IDLE;
            end
        endcase
        next_emit = 3'h0;
        if (next_state == oesc_pkg::ST_EXPOSE && next_slot != oesc_pkg::SLOT_AMB)
        begin
            // external emitters are fed by driver one through the mux
            next_emit = simul ? emit_en
                : (next_slot < oesc_pkg::SLOT_EXT_FIRST) ? 3'h1 << next_slot : 3'h1;
        end
        next_cancel = (next_state == oesc_pkg::ST_COMP);
        ext_exposing = (next_state == oesc_pkg::ST_EXPOSE) && (next_slot >= oesc_pkg::SLOT_EXT_FIRST)
            && (next_slot != oesc_pkg::SLOT_AMB);
        next_a_o = 1'b0;
        next_a_oe_n = 1'b1;
        next_b_o = 1'b0;
        next_b_oe_n = 1'b1;
        if ((mode == oesc_pkg::MODE_STANDALONE || mode == oesc_pkg::MODE_EXT_CLK) && abc_en)
        begin
            next_a_o = ~ext_exposing;
            next_a_oe_n = 1'b0;
        end
        else if (mode == oesc_pkg::MODE_TRIG && abc_en)
        begin
            next_b_o = ~ext_exposing;
            next_b_oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state <= oesc_pkg::ST_IDLE;
            slot <= 3'h0;
            phase_cnt <= 8'h00;
            emitter_drive_o <= 3'h0;
            amb_cancel_o <= 1'b0;
            conv_start_o <= 1'b0;
            fifo_push_o <= 1'b0;
            fifo_data_o <= 24'h000000;
            sync_pin_a_o <= 1'b0;
            sync_pin_a_oe_n_o <= 1'b1;
            sync_pin_b_o <= 1'b0;
            sync_pin_b_oe_n_o <= 1'b1;
        end
        else
        begin
            state <= next_state;
            slot <= next_slot;
            phase_cnt <= next_phase_cnt;
            emitter_drive_o <= next_emit;
            amb_cancel_o <= next_cancel;
            conv_start_o <= next_conv_start;
            fifo_push_o <= next_push;
            fifo_data_o <= next_fifo_data;
            sync_pin_a_o <= next_a_o;
            sync_pin_a_oe_n_o <= next_a_oe_n;
            sync_pin_b_o <= next_b_o;
            sync_pin_b_oe_n_o <= next_b_oe_n;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    a_push_follows_conv: assert property (
        state == oesc_pkg::ST_CONV && conv_done_i |=> fifo_push_o)
        else $error("conversion result not pushed");
    a_push_value_kept: assert property (
        fifo_push_o |-> fifo_data_o[18:0] == $past(conv_data_i))
        else $error("pushed value differs from conversion");
    a_cancel_first: assert property (
        state == oesc_pkg::ST_EXPOSE && $past(state) != oesc_pkg::ST_EXPOSE
        && slot != oesc_pkg::SLOT_AMB |-> $past(state) == oesc_pkg::ST_COMP)
        else $error("emitter exposure without ambient cancel");
    a_ambient_dark: assert property (
        state == oesc_pkg::ST_EXPOSE && slot == oesc_pkg::SLOT_AMB |-> emitter_drive_o == 3'h0)
        else $error("emitter lit during ambient exposure");
    a_simul_all_lit: assert property (
        $past(simul) && state == oesc_pkg::ST_EXPOSE && slot == 3'h0
        |-> emitter_drive_o == $past(emit_en))
        else $error("simultaneous window missing an emitter");
    a_ambient_last: assert property (
        fifo_push_o && fifo_data_o[23:19] == oesc_pkg::TAG_AMBIENT |-> state == oesc_pkg::ST_IDLE)
        else $error("ambient result not last in sample");
    a_mux_pin_low: assert property (
        $past(mode == oesc_pkg::MODE_STANDALONE && abc_en) && state == oesc_pkg::ST_EXPOSE
        && slot >= oesc_pkg::SLOT_EXT_FIRST && slot != oesc_pkg::SLOT_AMB
        |-> !sync_pin_a_o && !sync_pin_a_oe_n_o)
        else $error("pin a not low on external exposure");
    a_pins_float: assert property (
        $past(mode == oesc_pkg::MODE_STANDALONE && !abc_en)
        |-> sync_pin_a_oe_n_o && sync_pin_b_oe_n_o)
        else $error("sync pin driven while unused");
    a_trigger_start: assert property (
        $past(trig_mode) && $past(state) == oesc_pkg::ST_IDLE && state != oesc_pkg::ST_IDLE
        |-> $past(a_rise))
        else $error("slave sample started without trigger");
    a_pin_b_mux: assert property (
        $past(mode == oesc_pkg::MODE_TRIG) |-> sync_pin_a_oe_n_o && (sync_pin_b_oe_n_o == !$past(abc_en)))
        else $error("pin roles wrong in trigger mode");
    a_phase_on_tick: assert property (
        state == oesc_pkg::ST_EXPOSE && !tick |=> phase_cnt == $past(phase_cnt))
        else $error("exposure advanced without a tick");

    c_simul_ambient: cover property (
        simul && amb_en && fifo_push_o && fifo_data_o[23:19] == oesc_pkg::TAG_AMBIENT);
    c_three_seq: cover property (!simul && fifo_push_o && fifo_data_o[23:19] == 5'h03);
    c_trig_start: cover property (trig_mode && a_rise && state == oesc_pkg::ST_IDLE);
    c_ext_clock: cover property (ext_clk_mode && b_rise && state == oesc_pkg::ST_EXPOSE);
endmodule

/* tb/oesc_far_model.sv */
// far side model: converter, sample trigger source, pin b clock source toggling every CLK_HALF clocks
`timescale 1ns/1ps
module oesc_far_model #(
    parameter int CONV_LAT = 3,
    parameter int CLK_HALF = 4
) (
    input wire logic clk_i,
    input wire logic conv_start_i,
    input wire logic trig_req_i,
    input wire logic clk_run_i,
    output logic conv_done_o,
    output logic [18:0] conv_data_o,
    output logic trig_o,
    output logic ext_clk_o
);
    int lat = -1;
    int hc = 0;
    int tc = 0;
    logic [18:0] val = 19'h5A5A1;
    initial
    begin
        conv_done_o = 1'b0;
        conv_data_o = 19'h00000;
        trig_o = 1'b0;
        ext_clk_o = 1'b0;
    end
    // data only valid with done, so it toggles between answers
    always @(posedge clk_i)
    begin
        conv_done_o <= (lat == 0);
        conv_data_o <= (lat == 0) ? val : ~conv_data_o;
        if (lat == 0)
            val <= val + 19'h00101;
        if (conv_start_i)
            lat <= CONV_LAT;
        else if (lat >= 0)
            lat <= lat - 1;
    end
    // trigger pulse a few clocks wide, as an outside source gives it
    always @(posedge clk_i)
    begin
        if (trig_req_i)
            tc <= 4;
        else if (tc > 0)
            tc <= tc - 1;
        trig_o <= trig_req_i || tc > 1;
    end
    // external clock stands still unless enabled
    always @(posedge clk_i)
    begin
        if (!clk_run_i)
            hc <= 0;
        else if (hc == CLK_HALF - 1)
        begin
            hc <= 0;
            ext_clk_o <= ~ext_clk_o;
        end
        else
            hc <= hc + 1;
    end
endmodule

/* tb/optical_exposure_sync_control_tb.sv */
// self-checking bench for the exposure sequencer and sync pin control
`timescale 1ns/1ps
module optical_exposure_sync_control_tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic trig_req = 1'b0;
    logic clk_run = 1'b0;
    logic drv_a = 1'b0;
    logic drv_b = 1'b0;
    logic [7:0] rdata_o;
    logic a_o, a_oe_n, b_o, b_oe_n, amb_o, cs_o, cd, push, trig, xclk;
    logic [2:0] emit;
    logic [18:0] cdata;
    logic [23:0] fdata;
    logic [23:0] pq[$];
    logic [18:0] cq[$];
    logic [2:0] emit_or = 3'h0;
    logic amb_seen = 1'b0;
    logic full_seen = 1'b0;
    logic a_low = 1'b0;
    logic [7:0] d;
    int n_fail = 0;
    int total_checks = 0;
    // undriven pins rest high through the board pull-ups
    wire pin_a = !a_oe_n ? a_o : (drv_a ? trig : 1'b1);
    wire pin_b = !b_oe_n ? b_o : (drv_b ? xclk : 1'b1);

    oesc_top #(.SAMPLE_TICKS(32), .COMP_TICKS(1), .EXPOSE_TICKS(1), .OSC_DIV(4)) dut_u (
        .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sync_pin_a_i(pin_a),
        .sync_pin_a_o(a_o), .sync_pin_a_oe_n_o(a_oe_n), .sync_pin_b_i(pin_b),
        .sync_pin_b_o(b_o), .sync_pin_b_oe_n_o(b_oe_n), .emitter_drive_o(emit),
        .amb_cancel_o(amb_o), .conv_start_o(cs_o), .conv_done_i(cd),
        .conv_data_i(cdata), .fifo_push_o(push), .fifo_data_o(fdata));
    oesc_far_model far_u (
        .clk_i(clk_i), .conv_start_i(cs_o), .trig_req_i(trig_req), .clk_run_i(clk_run),
        .conv_done_o(cd), .conv_data_o(cdata), .trig_o(trig), .ext_clk_o(xclk));

    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        if (push)
            pq.push_back(fdata);
        if (cd)
            cq.push_back(cdata);
        emit_or = emit_or | emit;
        amb_seen = amb_seen | amb_o;
        full_seen = full_seen | (emit == emit_or && emit != 3'h0 && emit_or != 3'h1);
        a_low = a_low | (!a_oe_n && !a_o);
    end

    task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
        @(posedge clk_i);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic clear();
        pq.delete();
        cq.delete();
        emit_or = 3'h0;
        amb_seen = 1'b0;
        full_seen = 1'b0;
        a_low = 1'b0;
    endtask

    // runs until n entries arrive, then checks tags in order and values
    task automatic run_case(input logic [7:0] cfg, input int n, input logic [19:0] tags);
        int i;
        clear();
        wr(oesc_pkg::SEQ_CFG_ADDR, cfg);
        for (i = 0; i < 3000 && pq.size() < n; i++)
            @(posedge clk_i);
        wr(oesc_pkg::SEQ_CFG_ADDR, 8'h00);
        wait_clk(300);
        for (i = 0; i < n; i++)
        begin
            chk("tag", 24'(pq[i][23:19]), 24'(tags[19 - 5 * i -: 5]));
            chk("value", 24'(pq[i][18:0]), 24'(cq[i]));
        end
        chk("emitters lit", 24'(emit_or), 24'(cfg[3:1]));
        chk("ambient cancel", 24'(amb_seen), 24'h1);
        if ($countones(cfg[3:1]) > 1)
            chk("lit together", 24'(full_seen), 24'(cfg[0]));
        $display("test cfg %h done", cfg);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #400000;
        n_fail++;
        results();
    end

    initial
    begin
        wait_clk(2);
        reset_i <= 1'b0;
        @(posedge clk_i);
        rd(oesc_pkg::SYNC_CTRL_ADDR, d);
        chk("mode reset", 24'(d), 24'h0);
        wr(oesc_pkg::SYNC_CTRL_ADDR, 8'h0A);
        rd(oesc_pkg::SYNC_CTRL_ADDR, d);
        chk("mode rw", 24'(d), 24'h0A);
        rd(8'h20, d);
        chk("unmapped", 24'(d), 24'h0);
        wr(oesc_pkg::SYNC_CTRL_ADDR, 8'h00);
        wait_clk(2);
        chk("a floats", 24'(a_oe_n), 24'h1);
        chk("b off", 24'(b_oe_n), 24'h1);
        run_case(8'h22, 2, {5'h01, 5'h01, 10'h0});
        run_case(8'h32, 2, {5'h01, oesc_pkg::TAG_AMBIENT, 10'h0});
        run_case(8'h37, 2, {oesc_pkg::TAG_SIMUL, oesc_pkg::TAG_AMBIENT, 10'h0});
        run_case(8'h3F, 2, {oesc_pkg::TAG_SIMUL, oesc_pkg::TAG_AMBIENT, 10'h0});
        run_case(8'h3E, 4, {5'h01, 5'h02, 5'h03, oesc_pkg::TAG_AMBIENT});
        wr(oesc_pkg::SLOT_CFG_ADDR, 8'h01);
        run_case(8'h22, 2, {5'h01, 5'h04, 10'h0});
        chk("a low on ext slot", 24'(a_low), 24'h1);
        chk("a high idle", 24'({a_oe_n, a_o}), 24'h1);
        // clock mode: nothing happens while the pin b clock stands still
        drv_b <= 1'b1;
        wr(oesc_pkg::SYNC_CTRL_ADDR, 8'h01);
        clear();
        wr(oesc_pkg::SEQ_CFG_ADDR, 8'h22);
        wait_clk(600);
        chk("no clock no sample", 24'(pq.size()), 24'h0);
        wr(oesc_pkg::SEQ_CFG_ADDR, 8'h00);
        clk_run <= 1'b1;
        run_case(8'h22, 2, {5'h01, 5'h04, 10'h0});
        chk("b input", 24'(b_oe_n), 24'h1);
        clk_run <= 1'b0;
        drv_b <= 1'b0;
        drv_a <= 1'b1;
        wr(oesc_pkg::SYNC_CTRL_ADDR, 8'h02);
        clear();
        wr(oesc_pkg::SEQ_CFG_ADDR, 8'h22);
        wait_clk(600);
        chk("no trigger no sample", 24'(pq.size()), 24'h0);
        chk("a input", 24'(a_oe_n), 24'h1);
        chk("b mux high", 24'({b_oe_n, b_o}), 24'h1);
        trig_req <= 1'b1;
        @(posedge clk_i);
        trig_req <= 1'b0;
        wait_clk(400);
        chk("one sample per trigger", 24'(pq.size()), 24'h2);
        // second trigger lands while the first sample is still converting
        clear();
        repeat (2)
        begin
            trig_req <= 1'b1;
            @(posedge clk_i);
            trig_req <= 1'b0;
            wait_clk(12);
        end
        wait_clk(400);
        chk("busy trigger dropped", 24'(pq.size()), 24'h2);
        rd(oesc_pkg::STATUS_ADDR, d);
        chk("overrun set", 24'(d[oesc_pkg::STATUS_OVR_BIT]), 24'h1);
        wr(oesc_pkg::STATUS_ADDR, 8'h40);
        rd(oesc_pkg::STATUS_ADDR, d);
        chk("overrun clear", 24'(d[oesc_pkg::STATUS_OVR_BIT]), 24'h0);
        wr(oesc_pkg::SEQ_CFG_ADDR, 8'h00);
        $display("test trigger done");
        drv_b <= 1'b1;
        clk_run <= 1'b1;
        wr(oesc_pkg::SYNC_CTRL_ADDR, 8'h03);
        clear();
        wr(oesc_pkg::SEQ_CFG_ADDR, 8'h22);
        trig_req <= 1'b1;
        @(posedge clk_i);
        trig_req <= 1'b0;
        wait_clk(800);
        chk("trigger ext clock", 24'(pq.size()), 24'h2);
        chk("b input mode 3", 24'(b_oe_n), 24'h1);
        $display("test trigger clock done");
        results();
    end
endmodule
